//--- verif/gie_pin_model.sv
`timescale 1ns/10ps
// Far-side pin driver; levels move only just after a clock edge, so they are synchronous to pclk
module gie_pin_model (
   // Clock and wanted levels
   input  wire logic       pclk,
   input  wire logic [7:0] want,
   // Pin levels
   output logic      [7:0] gp_pins
);
   always_ff @(posedge pclk) begin
      gp_pins <= want;
   end
endmodule : gie_pin_model

//--- verif/gpio_edge_interrupt_enable_tb.sv
`timescale 1ns/10ps
`include "gie_regs.svh"
module gpio_edge_interrupt_enable_tb;
   typedef struct packed {logic m; logic [7:0] en; logic [7:0] p; logic [7:0] e;} gie_row_s;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, main_node = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0]  pstrb = 4'hF;
   logic [7:0]  want = 8'h00, gp_pins, pin_irq_req, seen;
   logic        pready, pslverr, irq, err;
   int          fail_count = 0, comparisons = 0, cyc = 0;
   gie_row_s    rows [10] = '{
      '{1'b0, 8'h80, 8'hFF, 8'h80},
      '{1'b0, 8'h40, 8'hFF, 8'h40},
      '{1'b0, 8'h20, 8'hFF, 8'h20},
      '{1'b0, 8'h10, 8'hFF, 8'h10},
      '{1'b0, 8'h08, 8'hFF, 8'h08},
      '{1'b0, 8'h04, 8'hFF, 8'h04},
      '{1'b0, 8'h02, 8'hFF, 8'h02},
      '{1'b0, 8'h01, 8'hFF, 8'h01},
      '{1'b1, 8'hFF, 8'hFF, 8'hFE},
      '{1'b0, 8'h00, 8'hFF, 8'h00}};
   always #5 pclk = ~pclk;
   gie_top #(.NPINS(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gp_pins(gp_pins), .main_node(main_node),
      .pin_irq_req(pin_irq_req), .irq(irq));
   gie_pin_model u_pins (.pclk(pclk), .want(want), .gp_pins(gp_pins));
   task print_verdict;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Read data and error are taken at the edge where pready is seen high, then one idle edge passes
   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task pulse(input logic [7:0] p);
      seen = 8'h00;
      want <= p;
      repeat (6) begin
         @(posedge pclk);
         seen |= pin_irq_req;
      end
   endtask : pulse
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset pready", 32'h0000_0001, {31'h0, pready});
      chk("reset irq", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, `GIE_OFF_IRQ_ENABLE, 32'h0000_0000);
      chk("enable reset", 32'h0000_0000, rd);
      apb(1'b1, `GIE_OFF_IRQ_ENABLE, 32'hFFFF_FF5A);
      pstrb <= 4'h0;
      apb(1'b1, `GIE_OFF_IRQ_ENABLE, 32'h0000_0000);
      pstrb <= 4'hF;
      apb(1'b0, `GIE_OFF_IRQ_ENABLE, 32'h0000_0000);
      chk("enable width", 32'h0000_005A, rd);
      apb(1'b0, 8'h7F, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      apb(1'b1, 8'h7F, 32'h0000_00FF);
      chk("unmapped write error", 32'h0000_0001, {31'h0, err});
      apb(1'b1, `GIE_OFF_INPUT_ENABLE, 32'h0000_00FF);
      apb(1'b1, `GIE_OFF_IRQ_MASK, 32'h0000_00FF);
      $display("test registers done");
      foreach (rows[i]) begin
         main_node <= rows[i].m;
         apb(1'b1, `GIE_OFF_IRQ_ENABLE, {24'h0, rows[i].en});
         pulse(8'h00);
         apb(1'b0, `GIE_OFF_IRQ_STATUS, 32'h0000_0000);
         pulse(rows[i].p);
         chk("row request", {24'h0, rows[i].e}, {24'h0, seen});
         chk("row irq", {31'h0, rows[i].e != 8'h00}, {31'h0, irq});
         apb(1'b0, `GIE_OFF_IRQ_STATUS, 32'h0000_0000);
         chk("row status", {24'h0, rows[i].e}, rd);
      end
      $display("test enable rows done");
      pulse(8'h00);
      apb(1'b1, `GIE_OFF_INPUT_ENABLE, 32'h0000_000F);
      apb(1'b1, `GIE_OFF_IRQ_ENABLE, 32'h0000_00FF);
      pulse(8'hFF);
      chk("input gated", 32'h0000_000F, {24'h0, seen});
      apb(1'b0, `GIE_OFF_INPUT_VALUE, 32'h0000_0000);
      chk("input value", 32'h0000_000F, rd);
      pulse(8'h00);
      apb(1'b1, `GIE_OFF_INPUT_ENABLE, 32'h0000_00FF);
      apb(1'b1, `GIE_OFF_POLARITY, 32'h0000_00F0);
      // Inverting a low pin is itself a rising level, so that request is let pass first
      pulse(8'h00);
      pulse(8'hFF);
      chk("invert rise", 32'h0000_000F, {24'h0, seen});
      pulse(8'h00);
      chk("invert fall", 32'h0000_00F0, {24'h0, seen});
      apb(1'b1, `GIE_OFF_IRQ_MASK, 32'h0000_0000);
      apb(1'b0, `GIE_OFF_IRQ_STATUS, 32'h0000_0000);
      pulse(8'h0F);
      chk("masked irq", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, `GIE_OFF_IRQ_STATUS, 32'h0000_0000);
      chk("masked status", 32'h0000_000F, rd);
      $display("test edge cases done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset request", 32'h0000_0000, {24'h0, pin_irq_req});
      chk("reset irq again", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, `GIE_OFF_IRQ_ENABLE, 32'h0000_0000);
      chk("enable after reset", 32'h0000_0000, rd);
      $display("test reset done");
      print_verdict();
   end
endmodule : gpio_edge_interrupt_enable_tb

//--- verilog/gie_pkg.sv
package gie_pkg;
   typedef logic [7:0] gie_byte_t;
   typedef struct packed {
      logic [7:0] irq_enable;
      logic [7:0] input_enable;
      logic [7:0] polarity;
      logic [7:0] mask;
   } gie_cfg_s;
   typedef enum logic [1:0] {
      GIE_IDLE   = 2'b01,
      GIE_ACCESS = 2'b10
   } gie_apb_e;
endpackage : gie_pkg

//--- verilog/gie_regs.svh
`ifndef GIE_REGS_SVH
`define GIE_REGS_SVH
`define GIE_OFF_INPUT_VALUE   8'h4F
`define GIE_OFF_INPUT_ENABLE  8'h4E
`define GIE_OFF_IRQ_ENABLE    8'h50
`define GIE_OFF_POLARITY      8'h51
`define GIE_OFF_IRQ_STATUS    8'h52
`define GIE_OFF_IRQ_MASK      8'h53
`define GIE_RST_BYTE          8'h00
`define GIE_PIN0              0
`define GIE_ADDR_LSB          2
`endif

//--- verilog/gie_top.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "gie_regs.svh"
// Summary of operation
// R1: An 8-bit read/write pin interrupt enable register sits at offset 0x50 and only input-enabled pins can request through it.
// R2: A pin whose enable bit is 1 raises a request on a rising edge, and a 0 bit suppresses it.
// R3: Bit 7 gates requests from general-purpose pin seven.
// R4: Bit 6 gates requests from the pin shared with the second receive data line.
// R5: Bit 5 gates requests from the pin shared with the first receive data line.
// R6: Bit 4 gates requests from the pin shared with the second transmit data line.
// R7: Bit 3 gates requests from the pin shared with the first transmit data line.
// R8: Bit 2 gates requests from the pin shared with the second address strap.
// R9: Bit 1 gates requests from the pin shared with the first address strap.
// R10: Bit 0 gates requests from the pin shared with the interrupt output and has no effect in a main node.
// R11: A pin's input path is live only while its input-enable bit is set, otherwise it reads low and makes no edge.
// R12: A set polarity-invert bit makes the falling edge the active one for that pin.
// R13: Each pin is sampled in the clock domain and an edge is flagged when the previous sample differs in the chosen direction.
module gie_top #(
   parameter int NPINS = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Pins and mode
   input  wire logic [NPINS-1:0] gp_pins,
   input  wire logic             main_node,
   // Requests
   output logic      [NPINS-1:0] pin_irq_req,
   output logic                  irq
);
   gie_pkg::gie_cfg_s            cfg_reg;
   logic             [NPINS-1:0] status_reg;
   logic             [NPINS-1:0] sample_reg;
   logic             [NPINS-1:0] gp_input_value;
   logic             [NPINS-1:0] level;
   logic             [NPINS-1:0] edge_hit;
   logic             [NPINS-1:0] gate;
   logic             [31:0]      rdata_next;
   logic             [7:0]       word;
   logic                         hit;
   logic                         wr_fire;
   logic                         rd_fire;
   logic                         rd_setup;

   // Single-cycle access; no wait states needed for flop registers
   assign pready  = 1'b1;
   assign word    = paddr[`GIE_ADDR_LSB+7:`GIE_ADDR_LSB];
   assign wr_fire = psel && penable && pwrite;
   assign rd_fire = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   always_comb begin
      hit = 1'b1;
      rdata_next = 32'h0000_0000;
      unique case (word)
         `GIE_OFF_INPUT_ENABLE: rdata_next[7:0] = cfg_reg.input_enable;
         `GIE_OFF_INPUT_VALUE:  rdata_next[7:0] = gp_input_value;
         `GIE_OFF_IRQ_ENABLE:   rdata_next[7:0] = cfg_reg.irq_enable; // R1
         `GIE_OFF_POLARITY:     rdata_next[7:0] = cfg_reg.polarity;
         `GIE_OFF_IRQ_STATUS:   rdata_next[7:0] = status_reg;
         `GIE_OFF_IRQ_MASK:     rdata_next[7:0] = cfg_reg.mask;
         default:               hit = 1'b0;
      endcase
   end

   // Unmapped addresses answer with an error and read as zero
   assign pslverr = psel && penable && !hit;

   // Loaded in the setup cycle so read data already stands at the edge that ends the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rdata_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= {4{`GIE_RST_BYTE}};
      end else if (wr_fire && pstrb[0]) begin
         unique case (word)
            `GIE_OFF_IRQ_ENABLE:   cfg_reg.irq_enable   <= pwdata[7:0]; // R1
            `GIE_OFF_INPUT_ENABLE: cfg_reg.input_enable <= pwdata[7:0];
            `GIE_OFF_POLARITY:     cfg_reg.polarity     <= pwdata[7:0];
            `GIE_OFF_IRQ_MASK:     cfg_reg.mask         <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Pin zero doubles as the interrupt output in a main node, so it is never an input there
   genvar i;
   generate
      for (i = 0; i < NPINS; i++) begin : g_pin
         if (i == `GIE_PIN0) begin : g_p0
            assign gp_input_value[i] = gp_pins[i] && cfg_reg.input_enable[i] && !main_node; // R11 R10
            assign gate[i]           = cfg_reg.irq_enable[i] && !main_node; // R10
         end else begin : g_pn
            assign gp_input_value[i] = gp_pins[i] && cfg_reg.input_enable[i]; // R11
            assign gate[i]           = cfg_reg.irq_enable[i]; // R3 R4 R5 R6 R7 R8 R9
         end
         // Inverting before the detector turns a falling pin into a rising level
         assign level[i]    = gp_input_value[i] ^ (cfg_reg.polarity[i] && cfg_reg.input_enable[i]); // R12
         assign edge_hit[i] = level[i] && !sample_reg[i] && cfg_reg.input_enable[i]; // R13
      end
   endgenerate

   // Reset sample is zero, so enabling the input of a non-inverted pin already high counts as a rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_reg <= NPINS'(`GIE_RST_BYTE);
      end else begin
         sample_reg <= level; // R13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_req <= NPINS'(`GIE_RST_BYTE);
      end else begin
         pin_irq_req <= edge_hit & gate; // R2
      end
   end

   // Only bits already in the read data clear, so no request after the setup cycle is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= NPINS'(`GIE_RST_BYTE);
      end else if (rd_fire && word == `GIE_OFF_IRQ_STATUS) begin
         status_reg <= (status_reg & ~prdata[NPINS-1:0]) | pin_irq_req;
      end else begin
         status_reg <= status_reg | pin_irq_req;
      end
   end

   assign irq = |(status_reg & cfg_reg.mask[NPINS-1:0]);

   property p_gate_off;
      @(posedge pclk) disable iff (!presetn)
      !gate[3] |=> !pin_irq_req[3];
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("request from a disabled pin"); // R2

   property p_rise_req;
      @(posedge pclk) disable iff (!presetn)
      (gate[7] && cfg_reg.input_enable[7] && !cfg_reg.polarity[7] && gp_pins[7] && !sample_reg[7])
         |=> pin_irq_req[7];
   endproperty
   a_rise_req: assert property (p_rise_req) else $error("rising edge on pin seven lost"); // R3

   property p_main_pin0;
      @(posedge pclk) disable iff (!presetn)
      main_node ##1 main_node |-> !pin_irq_req[0];
   endproperty
   a_main_pin0: assert property (p_main_pin0) else $error("pin zero requested in main node"); // R10

   property p_in_dis;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.input_enable[5] |-> !gp_input_value[5] ##1 (!pin_irq_req[5] || $past(cfg_reg.input_enable[5]));
   endproperty
   a_in_dis: assert property (p_in_dis) else $error("disabled input produced activity"); // R11

   property p_fall_req;
      @(posedge pclk) disable iff (!presetn)
      (gate[4] && cfg_reg.input_enable[4] && cfg_reg.polarity[4] && !gp_pins[4] && !sample_reg[4])
         |=> pin_irq_req[4];
   endproperty
   a_fall_req: assert property (p_fall_req) else $error("falling edge on inverted pin lost"); // R12

   property p_single;
      @(posedge pclk) disable iff (!presetn)
      pin_irq_req[6] |=> !pin_irq_req[6];
   endproperty
   a_single: assert property (p_single) else $error("request longer than one cycle"); // R13

   property p_en_rw;
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && pstrb[0] && word == `GIE_OFF_IRQ_ENABLE) |=> cfg_reg.irq_enable == $past(pwdata[7:0]);
   endproperty
   a_en_rw: assert property (p_en_rw) else $error("enable register write lost"); // R1

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      pin_irq_req[2] |=> status_reg[2];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit not set by request"); // R8

   property p_gate1;
      @(posedge pclk) disable iff (!presetn)
      pin_irq_req[1] |-> $past(cfg_reg.irq_enable[1]);
   endproperty
   a_gate1: assert property (p_gate1) else $error("pin one request without enable"); // R9

   property p_pin7_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.irq_enable[7] |=> !pin_irq_req[7];
   endproperty
   a_pin7_off: assert property (p_pin7_off) else $error("pin seven requested while disabled"); // R3

   property p_pin6_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.irq_enable[6] |=> !pin_irq_req[6];
   endproperty
   a_pin6_off: assert property (p_pin6_off) else $error("pin six requested while disabled"); // R4

   property p_pin6_on;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.irq_enable[6] && cfg_reg.input_enable[6] && !cfg_reg.polarity[6] && gp_pins[6] && !sample_reg[6])
         |=> pin_irq_req[6];
   endproperty
   a_pin6_on: assert property (p_pin6_on) else $error("rising edge on pin six lost"); // R4

   property p_pin5_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.irq_enable[5] |=> !pin_irq_req[5];
   endproperty
   a_pin5_off: assert property (p_pin5_off) else $error("pin five requested while disabled"); // R5

   property p_pin5_on;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.irq_enable[5] && cfg_reg.input_enable[5] && !cfg_reg.polarity[5] && gp_pins[5] && !sample_reg[5])
         |=> pin_irq_req[5];
   endproperty
   a_pin5_on: assert property (p_pin5_on) else $error("rising edge on pin five lost"); // R5

   property p_pin4_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.irq_enable[4] |=> !pin_irq_req[4];
   endproperty
   a_pin4_off: assert property (p_pin4_off) else $error("pin four requested while disabled"); // R6

   property p_pin4_on;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.irq_enable[4] && cfg_reg.input_enable[4] && !cfg_reg.polarity[4] && gp_pins[4] && !sample_reg[4])
         |=> pin_irq_req[4];
   endproperty
   a_pin4_on: assert property (p_pin4_on) else $error("rising edge on pin four lost"); // R6

   property p_pin3_on;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.irq_enable[3] && cfg_reg.input_enable[3] && !cfg_reg.polarity[3] && gp_pins[3] && !sample_reg[3])
         |=> pin_irq_req[3];
   endproperty
   a_pin3_on: assert property (p_pin3_on) else $error("rising edge on pin three lost"); // R7

   property p_pin2_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.irq_enable[2] |=> !pin_irq_req[2];
   endproperty
   a_pin2_off: assert property (p_pin2_off) else $error("pin two requested while disabled"); // R8

   property p_pin2_on;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.irq_enable[2] && cfg_reg.input_enable[2] && !cfg_reg.polarity[2] && gp_pins[2] && !sample_reg[2])
         |=> pin_irq_req[2];
   endproperty
   a_pin2_on: assert property (p_pin2_on) else $error("rising edge on pin two lost"); // R8

   property p_pin1_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.irq_enable[1] |=> !pin_irq_req[1];
   endproperty
   a_pin1_off: assert property (p_pin1_off) else $error("pin one requested while disabled"); // R9

   property p_pin1_on;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.irq_enable[1] && cfg_reg.input_enable[1] && !cfg_reg.polarity[1] && gp_pins[1] && !sample_reg[1])
         |=> pin_irq_req[1];
   endproperty
   a_pin1_on: assert property (p_pin1_on) else $error("rising edge on pin one lost"); // R9

   property p_pin0_off;
      @(posedge pclk) disable iff (!presetn)
      (!cfg_reg.irq_enable[0] || main_node) |=> !pin_irq_req[0];
   endproperty
   a_pin0_off: assert property (p_pin0_off) else $error("pin zero requested while disabled"); // R10

   property p_pin0_on;
      @(posedge pclk) disable iff (!presetn)
      (!main_node && cfg_reg.irq_enable[0] && cfg_reg.input_enable[0] && !cfg_reg.polarity[0])
         && (gp_pins[0] && !sample_reg[0]) |=> pin_irq_req[0];
   endproperty
   a_pin0_on: assert property (p_pin0_on) else $error("rising edge on pin zero lost"); // R10

   property p_in_dis6;
      @(posedge pclk) disable iff (!presetn)
      !cfg_reg.input_enable[6] |=> !pin_irq_req[6];
   endproperty
   a_in_dis6: assert property (p_in_dis6) else $error("request from a pin with its input off"); // R11

   property p_ie_read;
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && word == `GIE_OFF_INPUT_VALUE && !main_node)
         |=> prdata[7:0] == ($past(gp_pins) & $past(cfg_reg.input_enable));
   endproperty
   a_ie_read: assert property (p_ie_read) else $error("input value shows a disabled pin"); // R11

   property p_inv_quiet;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.polarity[7] && cfg_reg.input_enable[7] && gp_pins[7]) |=> !pin_irq_req[7];
   endproperty
   a_inv_quiet: assert property (p_inv_quiet) else $error("inverted pin requested while high"); // R12

   property p_rise_quiet;
      @(posedge pclk) disable iff (!presetn)
      (!cfg_reg.polarity[3] && !gp_pins[3]) |=> !pin_irq_req[3];
   endproperty
   a_rise_quiet: assert property (p_rise_quiet) else $error("pin three requested while low"); // R2

   property p_hold_quiet;
      @(posedge pclk) disable iff (!presetn)
      (gp_pins[5] && $past(gp_pins[5]) && $stable(cfg_reg)) |=> !pin_irq_req[5];
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("request from a steady pin"); // R13

   property p_irq_mask;
      @(posedge pclk) disable iff (!presetn)
      !(|cfg_reg.mask) |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt raised with all bits masked"); // R2

   property p_en_read;
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && word == `GIE_OFF_IRQ_ENABLE) |=> prdata[7:0] == $past(cfg_reg.irq_enable);
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable register read wrong"); // R1

   property p_read_hi;
      @(posedge pclk) disable iff (!presetn)
      rd_setup |=> prdata[31:8] == 24'h00_0000;
   endproperty
   a_read_hi: assert property (p_read_hi) else $error("upper read bits not zero"); // R1

   property p_prdata_hold;
      @(posedge pclk) disable iff (!presetn)
      !rd_setup |=> $stable(prdata);
   endproperty
   a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved outside a read"); // R1

   property p_strb_off;
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && !pstrb[0]) |=> $stable(cfg_reg);
   endproperty
   a_strb_off: assert property (p_strb_off) else $error("write without byte strobe landed"); // R1
endmodule : gie_top
